// ==== rtl/hall_six_step_commutator.sv ====
`timescale 1ns/1ns

module hall_six_step_commutator #(
   parameter int PWM_PERIOD = bldc_pkg::PWM_CYCLES,
   parameter int TICK_LEN   = bldc_pkg::TICK_CYCLES,
   parameter int PRECHARGE  = bldc_pkg::PRECHARGE_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [2:0]  hall_i,
   input  wire logic        estop_input_i,
   input  wire logic        overcurrent_fault_input_i,
   output logic      [2:0]  gate_hi_o,
   output logic      [2:0]  gate_lo_o,
   output logic             overcurrent_level1_indicator_o
);

   typedef struct packed {
      logic [2:0]            hall_m;
      logic [2:0]            hall_s;
      logic [2:0]            hall_q;
      logic                  oc_m;
      logic                  oc_s;
      logic                  es_m;
      logic                  es_s;
      bldc_pkg::mstate_t     st;
      logic [2:0]            ctrl;
      logic [15:0]           speed_req;
      logic [15:0]           kp;
      logic [15:0]           ki;
      logic [15:0]           ramp;
      logic signed [35:0]    ui;
      logic [15:0]           duty;
      logic [15:0]           pwm_cnt;
      logic [19:0]           tick_cnt;
      logic [19:0]           pre_cnt;
      logic [6:0]            psc;
      logic [15:0]           cap_cnt;
      logic [15:0]           period;
      logic                  still;
      logic [5:0]            cmd;
      logic [2:0][6:0]       dt;
      logic [2:0][1:0]       req_last;
      logic [2:0]            gh;
      logic [2:0]            gl;
      logic                  oc_flag;
      logic                  es_flag;
      logic                  oc_ind;
      logic                  ack;
      logic [31:0]           rdat;
   } state_t;

   localparam state_t STATE_RST = '0;

   state_t r_r;
   state_t r_nxt;

   // Drive requests per phase, {top, bottom}
   logic [2:0][1:0]    req;
   logic               pwm_on;
   logic [15:0]        spd;
   logic [31:0]        quot;
   logic               start_ok;
   logic               hall_edge;
   logic               a_rise;
   logic               ptick;
   logic               ovf;
   logic               req_wr;
   logic signed [16:0] err;
   logic signed [33:0] p_term;
   logic signed [33:0] i_inc;
   logic signed [35:0] ui_new;
   logic signed [35:0] u_sum;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
      logic [15:0] m;
      m = old;
      if (sel[0]) m[7:0] = d[7:0];
      if (sel[1]) m[15:8] = d[15:8];
      return m;
   endfunction : merge16

   // Hall code {A,B,C} to drive codes {A,B,C}
   function automatic logic [5:0] comm_map(input logic [2:0] h, input logic ccw);
      logic [5:0] m;
      m = '0;
      case (h)
         3'h3:    m = {bldc_pkg::DRV_NEG, bldc_pkg::DRV_POS, bldc_pkg::DRV_NC};
         3'h2:    m = {bldc_pkg::DRV_NC,  bldc_pkg::DRV_POS, bldc_pkg::DRV_NEG};
         3'h6:    m = {bldc_pkg::DRV_POS, bldc_pkg::DRV_NC,  bldc_pkg::DRV_NEG};
         3'h4:    m = {bldc_pkg::DRV_POS, bldc_pkg::DRV_NEG, bldc_pkg::DRV_NC};
         3'h5:    m = {bldc_pkg::DRV_NC,  bldc_pkg::DRV_NEG, bldc_pkg::DRV_POS};
         3'h1:    m = {bldc_pkg::DRV_NEG, bldc_pkg::DRV_NC,  bldc_pkg::DRV_POS};
         default: m = '0;
      endcase
      // Each valid entry has exactly one positive and one negative phase; codes 0 and 7 drive none
      if (ccw) begin
         for (int i = 0; i < 3; i++) begin
            if (m[2*i+:2] != bldc_pkg::DRV_NC) m[2*i+:2] = ~m[2*i+:2];
         end
      end
      return m;
   endfunction : comm_map

   assign pwm_on = r_r.pwm_cnt < r_r.duty;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_phase
         logic [1:0] code;
         logic       comp;
         assign code = r_r.cmd[2*gi+:2];
         assign comp = r_r.ctrl[bldc_pkg::CTRL_COMP_BIT];
         always_comb begin
            req[gi] = 2'h0;
            if (r_r.st == bldc_pkg::ST_PRECHARGE) begin
               req[gi] = 2'h1;
            end else if (code == bldc_pkg::DRV_POS) begin
               req[gi] = {pwm_on, comp & ~pwm_on};
            end else if (code == bldc_pkg::DRV_NEG) begin
               req[gi] = comp ? {~pwm_on, pwm_on} : {1'b0, pwm_on};
            end
         end
      end
   endgenerate

   // Combinational divide traded for area; result settles well within a cycle at speed rates
   assign quot = (r_r.period == 16'h0000) ? 32'h0 : bldc_pkg::SPEED_NUM / {16'h0000, r_r.period};
   assign spd  = r_r.still ? 16'h0000 : ((quot > 32'h0000FFFF) ? 16'hFFFF : quot[15:0]);

   always_comb begin
      r_nxt     = r_r;
      hall_edge = r_r.hall_s != r_r.hall_q;
      a_rise    = r_r.hall_s[2] & ~r_r.hall_q[2];
      ptick     = 1'b0;
      ovf       = 1'b0;
      req_wr    = wb_cyc_i & wb_stb_i & wb_we_i & r_r.ack;
      start_ok  = r_r.ctrl[bldc_pkg::CTRL_EN_BIT] & (r_r.speed_req != 16'h0000) & ~r_r.es_s & ~r_r.oc_flag;
      err       = $signed({1'b0, r_r.ramp}) - $signed({1'b0, spd});
      p_term    = $signed({1'b0, r_r.kp}) * err;
      i_inc     = $signed({1'b0, r_r.ki}) * err;
      ui_new    = (spd < bldc_pkg::MIN_RPM) ? r_r.ui : r_r.ui + 36'(i_inc);
      u_sum     = (36'(p_term) + ui_new) >>> bldc_pkg::PI_SHIFT;

      // Synchronisers
      r_nxt.hall_m = hall_i;
      r_nxt.hall_s = r_r.hall_m;
      r_nxt.hall_q = r_r.hall_s;
      r_nxt.oc_m   = overcurrent_fault_input_i;
      r_nxt.oc_s   = r_r.oc_m;
      r_nxt.es_m   = estop_input_i;
      r_nxt.es_s   = r_r.es_m;
      r_nxt.oc_ind = r_r.oc_s;

      // Wishbone slave: ack one cycle after request, write commits at the acked edge
      r_nxt.ack = wb_cyc_i & wb_stb_i & ~r_r.ack;
      if (wb_cyc_i & wb_stb_i & ~r_r.ack) begin
         case (wb_adr_i)
            bldc_pkg::ADR_CTRL:   r_nxt.rdat = {29'h0, r_r.ctrl};
            bldc_pkg::ADR_SPEED:  r_nxt.rdat = {16'h0, r_r.speed_req};
            bldc_pkg::ADR_KP:     r_nxt.rdat = {16'h0, r_r.kp};
            bldc_pkg::ADR_KI:     r_nxt.rdat = {16'h0, r_r.ki};
            bldc_pkg::ADR_STATUS: r_nxt.rdat = {21'h0, r_r.hall_s, 2'h0, r_r.st, r_r.oc_s,
                                                r_r.still, r_r.es_flag, r_r.oc_flag};
            bldc_pkg::ADR_PERIOD: r_nxt.rdat = {16'h0, r_r.period};
            bldc_pkg::ADR_MEAS:   r_nxt.rdat = {16'h0, spd};
            bldc_pkg::ADR_DUTY:   r_nxt.rdat = {16'h0, r_r.duty};
            default:              r_nxt.rdat = 32'h0;
         endcase
      end
      if (req_wr) begin
         case (wb_adr_i)
            bldc_pkg::ADR_CTRL: begin
               if (wb_sel_i[0]) r_nxt.ctrl = wb_dat_i[2:0];
            end
            bldc_pkg::ADR_SPEED: r_nxt.speed_req = merge16(r_r.speed_req, wb_dat_i, wb_sel_i);
            bldc_pkg::ADR_KP:    r_nxt.kp = merge16(r_r.kp, wb_dat_i, wb_sel_i);
            bldc_pkg::ADR_KI:    r_nxt.ki = merge16(r_r.ki, wb_dat_i, wb_sel_i);
            bldc_pkg::ADR_STATUS: begin
               if (wb_sel_i[0] & wb_dat_i[bldc_pkg::ST_OC_BIT]) r_nxt.oc_flag = 1'b0;
               if (wb_sel_i[0] & wb_dat_i[bldc_pkg::ST_ES_BIT]) r_nxt.es_flag = 1'b0;
            end
            default: ;
         endcase
      end

      // Sticky fault flags; set placed after the clear so it wins
      if (r_r.oc_s) r_nxt.oc_flag = 1'b1;
      if (r_r.es_s) r_nxt.es_flag = 1'b1;

      // PWM carrier, one counter shared by the paired channels
      r_nxt.pwm_cnt = (r_r.pwm_cnt >= 16'(PWM_PERIOD - 1)) ? 16'h0000 : r_r.pwm_cnt + 16'h0001;

      // Speed capture on Hall A rising edge
      if (r_r.psc == 7'(bldc_pkg::CAP_PRESCALE - 1)) begin
         r_nxt.psc = 7'h00;
         ptick     = 1'b1;
      end else begin
         r_nxt.psc = r_r.psc + 7'h01;
      end
      if (a_rise) begin
         r_nxt.period  = r_r.cap_cnt;
         r_nxt.cap_cnt = 16'h0000;
         r_nxt.still   = 1'b0;
      end else if (ptick) begin
         if (r_r.cap_cnt == bldc_pkg::CAP_MODULO) begin
            r_nxt.cap_cnt = 16'h0000;
            r_nxt.still   = 1'b1;
            ovf           = 1'b1;
            r_nxt.period  = 16'h0000;
         end else begin
            r_nxt.cap_cnt = r_r.cap_cnt + 16'h0001;
         end
      end

      case (r_r.st)
         bldc_pkg::ST_IDLE: begin
            r_nxt.cmd      = '0;
            r_nxt.duty     = 16'h0000;
            r_nxt.tick_cnt = 20'h00000;
            r_nxt.ramp     = 16'h0000;
            r_nxt.ui       = '0;
            r_nxt.pre_cnt  = 20'h00000;
            if (start_ok) r_nxt.st = bldc_pkg::ST_PRECHARGE;
         end
         bldc_pkg::ST_PRECHARGE: begin
            r_nxt.pre_cnt = r_r.pre_cnt + 20'h00001;
            if (!start_ok) begin
               r_nxt.st = bldc_pkg::ST_IDLE;
            end else if (r_r.pre_cnt == 20'(PRECHARGE - 1)) begin
               r_nxt.st  = bldc_pkg::ST_RUN;
               r_nxt.cmd = comm_map(r_r.hall_s, r_r.ctrl[bldc_pkg::CTRL_DIR_BIT]);
            end
         end
         bldc_pkg::ST_RUN: begin
            if (!start_ok) begin
               r_nxt.st   = bldc_pkg::ST_IDLE;
               r_nxt.cmd  = '0;
               r_nxt.duty = 16'h0000;
            end else begin
               if (hall_edge) begin
                  r_nxt.cmd = comm_map(r_r.hall_s, r_r.ctrl[bldc_pkg::CTRL_DIR_BIT]);
               end
               if (r_r.tick_cnt == 20'(TICK_LEN - 1)) begin
                  r_nxt.tick_cnt = 20'h00000;
                  if (r_r.ramp < r_r.speed_req) begin
                     r_nxt.ramp = (r_r.speed_req - r_r.ramp > bldc_pkg::RAMP_STEP) ?
                                  r_r.ramp + bldc_pkg::RAMP_STEP : r_r.speed_req;
                  end else begin
                     r_nxt.ramp = (r_r.ramp - r_r.speed_req > bldc_pkg::RAMP_STEP) ?
                                  r_r.ramp - bldc_pkg::RAMP_STEP : r_r.speed_req;
                  end
                  r_nxt.ui = ui_new;
                  if (u_sum < 36'sd0) begin
                     r_nxt.duty = 16'h0000;
                  end else if (u_sum > 36'(PWM_PERIOD)) begin
                     r_nxt.duty = 16'(PWM_PERIOD);
                  end else begin
                     r_nxt.duty = u_sum[15:0];
                  end
               end else begin
                  r_nxt.tick_cnt = r_r.tick_cnt + 20'h00001;
               end
            end
         end
         default: r_nxt.st = bldc_pkg::ST_IDLE;
      endcase

      // Overflow restarts ramp and integrator once; holding them at zero would never let a stopped motor start
      if (ovf) begin
         r_nxt.ramp = 16'h0000;
         r_nxt.ui   = '0;
      end

      // Dead time: any change of a phase request blanks both switches first
      for (int i = 0; i < 3; i++) begin
         r_nxt.req_last[i] = req[i];
         if (req[i] != r_r.req_last[i]) begin
            r_nxt.dt[i] = 7'(bldc_pkg::DEAD_CYCLES);
            r_nxt.gh[i] = 1'b0;
            r_nxt.gl[i] = 1'b0;
         end else if (r_r.dt[i] != 7'h00) begin
            r_nxt.dt[i] = r_r.dt[i] - 7'h01;
            r_nxt.gh[i] = 1'b0;
            r_nxt.gl[i] = 1'b0;
         end else begin
            r_nxt.gh[i] = req[i][1];
            r_nxt.gl[i] = req[i][0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_r           <= STATE_RST;
         r_r.ctrl      <= bldc_pkg::CTRL_RST;
         r_r.kp        <= bldc_pkg::KP_RST;
         r_r.ki        <= bldc_pkg::KI_RST;
         r_r.still     <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign wb_dat_o                       = r_r.rdat;
   assign wb_ack_o                       = r_r.ack;
   assign gate_hi_o                      = r_r.gh;
   assign gate_lo_o                      = r_r.gl;
   assign overcurrent_level1_indicator_o = r_r.oc_ind;

endmodule : hall_six_step_commutator

// ==== rtl/bldc_pkg.sv ====
package bldc_pkg;

   // Clock and timing
   localparam int CLK_HZ           = 100_000_000;
   localparam int CLK_PERIOD_NS    = 10;
   localparam int PWM_FREQ_HZ      = 19_200;
   localparam int PWM_CYCLES       = CLK_HZ / PWM_FREQ_HZ;
   localparam int DEAD_TIME_NS     = 1_000;
   localparam int DEAD_CYCLES      = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_MS          = 10;
   localparam int TICK_CYCLES      = (CLK_HZ / 1_000) * TICK_MS;
   localparam int PRECHARGE_US     = 1_000;
   localparam int PRECHARGE_CYCLES = (CLK_HZ / 1_000_000) * PRECHARGE_US;

   // Speed capture and speed loop
   localparam int          CAP_PRESCALE = 128;
   localparam logic [15:0] CAP_MODULO   = 16'hFFFF;
   localparam logic [31:0] SPEED_NUM    = 32'(60 * (CLK_HZ / CAP_PRESCALE));
   localparam logic [15:0] MIN_RPM      = 16'h01F3;
   localparam logic [15:0] RAMP_STEP    = 16'h0010;
   localparam int          PI_SHIFT     = 8;

   // Register byte offsets
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_SPEED  = 8'h04;
   localparam logic [7:0] ADR_KP     = 8'h08;
   localparam logic [7:0] ADR_KI     = 8'h0C;
   localparam logic [7:0] ADR_STATUS = 8'h10;
   localparam logic [7:0] ADR_PERIOD = 8'h14;
   localparam logic [7:0] ADR_MEAS   = 8'h18;
   localparam logic [7:0] ADR_DUTY   = 8'h1C;

   // Control and status fields
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_DIR_BIT   = 1;
   localparam int CTRL_COMP_BIT  = 2;
   localparam int ST_OC_BIT      = 0;
   localparam int ST_ES_BIT      = 1;
   localparam int ST_STILL_BIT   = 2;
   localparam int ST_OCLIVE_BIT  = 3;
   localparam int ST_STATE_LSB   = 4;
   localparam int ST_HALL_LSB    = 8;

   localparam logic [2:0]  CTRL_RST  = 3'h4;
   localparam logic [15:0] KP_RST    = 16'h0100;
   localparam logic [15:0] KI_RST    = 16'h0010;

   // Per-phase drive codes
   localparam logic [1:0] DRV_NC  = 2'h0;
   localparam logic [1:0] DRV_POS = 2'h1;
   localparam logic [1:0] DRV_NEG = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PRECHARGE,
      ST_RUN
   } mstate_t;

endpackage : bldc_pkg

// ==== verif/hall_six_step_commutator_checker.sv ====
`timescale 1ns/1ns
module hall_six_step_commutator_checker (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic [2:0] hall_i,
   input wire logic       estop_input_i,
   input wire logic       overcurrent_fault_input_i,
   input wire logic [2:0] gate_hi_o,
   input wire logic [2:0] gate_lo_o,
   input wire logic       overcurrent_level1_indicator_o
);
   // One cycle of margin on the blank, the counter starts one edge late
   localparam int DEAD_MIN = bldc_pkg::DEAD_CYCLES - 1;
   logic [7:0] off_cnt_r [3];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   always_ff @(posedge clk_i) begin
      for (int k = 0; k < 3; k++) begin
         if (rst_i || gate_hi_o[k] || gate_lo_o[k])
            off_cnt_r[k] <= 8'h00;
         else if (off_cnt_r[k] != 8'hFF)
            off_cnt_r[k] <= off_cnt_r[k] + 8'h01;
      end
   end

   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   ack_reply_a: assert property (req_s |=> ack_s) else $error("ack not a single pulse after request");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   no_shoot_a: assert property ((gate_hi_o & gate_lo_o) == 3'h0) else $error("both gates of a phase on");
   two_phase_a: assert property ((gate_hi_o != 3'h0) |-> ((gate_hi_o | gate_lo_o) != 3'h7))
      else $error("three phases driven");
   bad_hall_a: assert property ((hall_i == 3'h0 || hall_i == 3'h7) [*8] |-> (gate_hi_o | gate_lo_o) == 3'h0)
      else $error("gates on with invalid hall code");
   estop_halt_a: assert property (estop_input_i [*8] |-> (gate_hi_o | gate_lo_o) == 3'h0)
      else $error("gates on during emergency stop");
   oc_halt_a: assert property (overcurrent_fault_input_i [*8] |-> (gate_hi_o | gate_lo_o) == 3'h0)
      else $error("gates on during overcurrent");
   oc_follow_a: assert property (!$past(rst_i, 3) |->
      overcurrent_level1_indicator_o == $past(overcurrent_fault_input_i, 3)) else $error("indicator lag wrong");
   for (genvar k = 0; k < 3; k++) begin : g_ph
      dead_time_a: assert property ($rose(gate_hi_o[k] || gate_lo_o[k]) |-> off_cnt_r[k] >= DEAD_MIN)
         else $error("gate turned on inside dead time");
   end
endmodule : hall_six_step_commutator_checker

// ==== verif/motor_stage_model.sv ====
`timescale 1ns/1ns
module motor_stage_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [2:0] gate_hi_i,
   input  wire logic [2:0] gate_lo_i,
   input  wire logic       step_i,
   input  wire logic       ccw_i,
   input  wire logic       bad_i,
   input  wire logic       oc_req_i,
   output logic      [2:0] hall_o,
   output logic            oc_o
);
   localparam logic [2:0] SEQ [6] = '{3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h1};
   logic [2:0] idx_r;

   // Rotor advances one sector per step, backwards when counterclockwise
   always_ff @(posedge clk_i) begin
      if (rst_i)
         idx_r <= 3'h0;
      else if (step_i && ccw_i)
         idx_r <= (idx_r == 3'h0) ? 3'h5 : idx_r - 3'h1;
      else if (step_i)
         idx_r <= (idx_r == 3'h5) ? 3'h0 : idx_r + 3'h1;
   end
   // Only sensor levels reach the Hall pins; a broken harness reads all low
   assign hall_o = bad_i ? 3'h0 : SEQ[idx_r];
   // Pre-driver also trips on shoot-through, not only on command
   assign oc_o = oc_req_i || ((gate_hi_i & gate_lo_i) != 3'h0);
endmodule : motor_stage_model

// ==== verif/hall_six_step_commutator_tb.sv ====
`timescale 1ns/1ns
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
   $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module hall_six_step_commutator_tb;
   localparam int PWM_P = 400;
   localparam int TICK_P = 200;
   localparam int PRE_P = 300;
   localparam logic [2:0] CW_SEQ [6] = '{3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h1};
   // Low sides show for the precharge time less the turn-on blank
   localparam int PRE_LOW = PRE_P - bldc_pkg::DEAD_CYCLES - 1;
   localparam logic [7:0]  REG_ADR [5] = '{bldc_pkg::ADR_CTRL, bldc_pkg::ADR_SPEED, bldc_pkg::ADR_KP,
                                           bldc_pkg::ADR_KI, 8'h20};
   localparam logic [31:0] REG_RST [5] = '{{29'h0, bldc_pkg::CTRL_RST}, 32'h0, {16'h0, bldc_pkg::KP_RST},
                                           {16'h0, bldc_pkg::KI_RST}, 32'h0};
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [3:0]  sel = 4'h0;
   logic        ack, oc_pin, oc_ind;
   logic        estop = 1'b0, step = 1'b0, ccw = 1'b0, bad = 1'b0, oc_req = 1'b0;
   logic [2:0]  hall, g_hi, g_lo;
   int          n_fail = 0, check_count = 0, cyc_count = 0;

   always #5 clk_i = ~clk_i;

   hall_six_step_commutator #(.PWM_PERIOD(PWM_P), .TICK_LEN(TICK_P), .PRECHARGE(PRE_P)) hall_six_step_commutator_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .hall_i(hall),
      .estop_input_i(estop), .overcurrent_fault_input_i(oc_pin), .gate_hi_o(g_hi), .gate_lo_o(g_lo),
      .overcurrent_level1_indicator_o(oc_ind));
   motor_stage_model motor_stage_model_i (
      .clk_i(clk_i), .rst_i(rst_i), .gate_hi_i(g_hi), .gate_lo_i(g_lo), .step_i(step), .ccw_i(ccw),
      .bad_i(bad), .oc_req_i(oc_req), .hall_o(hall), .oc_o(oc_pin));

   task conclude;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   always @(posedge clk_i) begin
      cyc_count++;
      if (cyc_count == 40000) begin
         n_fail++;
         conclude();
      end
   end

   // Waits for ack however long it takes; only the bench timeout ends a hung access
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task do_step(input logic rev);
      ccw <= rev;
      step <= 1'b1;
      @(posedge clk_i);
      step <= 1'b0;
      @(posedge clk_i);
   endtask : do_step

   // Settle past sync and blanking, then gather every gate seen over two PWM periods
   task sector(input logic [2:0] code, input logic rev, input logic comp);
      logic [2:0] hs, ls;
      logic [5:0] e;
      hs = 3'h0;
      ls = 3'h0;
      case (code)
         3'h3: e = {3'h2, 3'h4};
         3'h2: e = {3'h2, 3'h1};
         3'h6: e = {3'h4, 3'h1};
         3'h4: e = {3'h4, 3'h2};
         3'h5: e = {3'h1, 3'h2};
         default: e = {3'h1, 3'h4};
      endcase
      if (rev)
         e = {e[2:0], e[5:3]};
      repeat (300) @(posedge clk_i);
      repeat (2 * PWM_P) begin
         @(posedge clk_i);
         hs |= g_hi;
         ls |= g_lo;
      end
      if (comp) begin
         `CHK("driven phases", e[5:3] | e[2:0], hs | ls)
      end else begin
         `CHK("top gates", e[5:3], hs)
         `CHK("bottom gates", e[2:0], ls)
      end
   endtask : sector

   task t_regs;
      wb(1'b1, 8'h20, 32'h5A5A, q);
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, REG_ADR[i], 32'h0, q);
         `CHK("reset register", REG_RST[i], q)
      end
      wb(1'b0, 8'h10, 32'h0, q);
      `CHK("standstill at reset", 1'b1, q[2])
      $display("test regs done");
   endtask : t_regs

   task t_start;
      int n;
      n = 0;
      wb(1'b1, 8'h04, 32'h3E8, q);
      wb(1'b1, 8'h00, 32'h1, q);
      while (g_lo !== 3'h7 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      `CHK("precharge tops", 3'h0, g_hi)
      n = 0;
      while (g_lo === 3'h7 && n < 1000) begin
         @(posedge clk_i);
         n++;
      end
      `CHK("precharge length", 1'b1, n >= PRE_LOW - 5 && n <= PRE_LOW + 5)
      wb(1'b0, 8'h10, 32'h0, q);
      `CHK("run state", 2'h2, q[5:4])
      $display("test start done");
   endtask : t_start

   task t_rotate;
      repeat (20 * TICK_P) @(posedge clk_i);
      sector(3'h3, 1'b0, 1'b0);
      do_step(1'b0);
      sector(3'h2, 1'b0, 1'b0);
      wb(1'b1, 8'h00, 32'h3, q);
      do_step(1'b1);
      sector(3'h3, 1'b1, 1'b0);
      do_step(1'b1);
      sector(3'h1, 1'b1, 1'b0);
      wb(1'b1, 8'h00, 32'h5, q);
      for (int i = 0; i < 6; i++) begin
         do_step(1'b0);
         sector(CW_SEQ[i], 1'b0, 1'b1);
      end
      $display("test rotate done");
   endtask : t_rotate

   task t_faults;
      int n;
      n = 0;
      bad <= 1'b1;
      repeat (20) @(posedge clk_i);
      `CHK("gates on bad code", 6'h00, {g_hi, g_lo})
      bad <= 1'b0;
      oc_req <= 1'b1;
      repeat (20) @(posedge clk_i);
      `CHK("gates on overcurrent", 6'h00, {g_hi, g_lo})
      `CHK("overcurrent indicator", 1'b1, oc_ind)
      oc_req <= 1'b0;
      repeat (400) @(posedge clk_i);
      wb(1'b0, 8'h10, 32'h0, q);
      `CHK("sticky overcurrent idle", 3'h1, {q[5:4], q[0]})
      wb(1'b1, 8'h10, 32'h1, q);
      while (g_lo !== 3'h7 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      `CHK("restart precharge", 3'h7, g_lo)
      estop <= 1'b1;
      repeat (20) @(posedge clk_i);
      `CHK("gates on estop", 6'h00, {g_hi, g_lo})
      wb(1'b0, 8'h10, 32'h0, q);
      `CHK("estop flag", 1'b1, q[1])
      estop <= 1'b0;
      $display("test faults done");
   endtask : t_faults

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_start();
      t_rotate();
      t_faults();
      conclude();
   end
endmodule : hall_six_step_commutator_tb

bind hall_six_step_commutator hall_six_step_commutator_checker hall_six_step_commutator_checker_i (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .hall_i(hall_i), .estop_input_i(estop_input_i), .overcurrent_fault_input_i(overcurrent_fault_input_i),
   .gate_hi_o(gate_hi_o), .gate_lo_o(gate_lo_o), .overcurrent_level1_indicator_o(overcurrent_level1_indicator_o));
